/* common/cmpp_pkg.sv */
/*
 * Package of the code memory panel programmer: command codes, control
 * register layout, memory geometry and timing constants.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cmpp_pkg;
    // Serial frame
    localparam int unsigned CMD_BITS = 4;
    localparam int unsigned PAYLOAD_BITS = 16;
    localparam int unsigned FRAME_BITS = CMD_BITS + PAYLOAD_BITS;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'hc;
    localparam logic [3:0] CMD_WRITE_INC = 4'hd;
    localparam logic [3:0] CMD_WRITE_START = 4'hf;
    localparam logic [4:0] NOP_HOLD_EDGE = 5'h04;
    // Table pointer and control register
    localparam int unsigned PTR_BITS = 22;
    localparam logic [21:0] PROG_CTRL_ADDR = 22'h3c0006;
    localparam logic [21:0] PTR_STEP = 22'h000002;
    localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
    localparam int unsigned PROG_CTRL_MULTI_BIT = 6;
    localparam logic [7:0] PROG_CTRL_MULTI_VAL = 8'h40;
    // Memory control bits set by core instructions
    localparam int unsigned MC_PGM_BIT = 7;
    localparam int unsigned MC_CFG_BIT = 6;
    localparam int unsigned MC_WRITE_ENABLE_BIT_BIT = 2;
    localparam logic [7:0] MC_RESET = 8'h00;
    // Core instructions recognised (opcode byte, file byte)
    localparam logic [7:0] OP_MOVLW = 8'h0e;
    localparam logic [7:0] OP_MOVWF = 8'h6e;
    localparam logic [7:0] OP_CLRF = 8'h6a;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;
    localparam logic [7:0] REG_MC = 8'ha6;
    localparam logic [7:0] REG_PTR_U = 8'hf8;
    localparam logic [7:0] REG_PTR_H = 8'hf7;
    localparam logic [7:0] REG_PTR_L = 8'hf6;
    // Write-enable set command, decoded as a whole word ahead of the bit-set form
    localparam logic [15:0] CORE_SET_WRITE_ENABLE_BIT = 16'h86a6;
    // Geometry
    localparam int unsigned BUF_BYTES = 8;
    localparam int unsigned PANEL_BITS = 13;
    typedef enum {CMPP_IDLE, CMPP_WAIT_NOP, CMPP_PROGRAM} cmpp_state_type;
endpackage : cmpp_pkg

/* common/cmpp_mem_if.sv */
/*
 * Interface between the sequencer and its panel memory: buffer loads,
 * programming strobe, read port.
 * Assumes both ends share the sequencer clock.
 */
`timescale 1ns/1ps
interface cmpp_mem_if #(parameter int PANELS = 4, parameter int AW = 22);
    logic buf_we;
    logic [$clog2(PANELS > 1 ? PANELS : 2)-1:0] buf_panel;
    logic [2:0] buf_idx;
    logic [15:0] buf_word;
    logic prog_go;
    logic prog_multi;
    logic [AW-1:0] prog_addr;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    modport seq (output buf_we, buf_panel, buf_idx, buf_word, prog_go, prog_multi,
        prog_addr, rd_addr, input rd_data);
    modport mem (input buf_we, buf_panel, buf_idx, buf_word, prog_go, prog_multi,
        prog_addr, rd_addr, output rd_data);
endinterface : cmpp_mem_if

/* rtl/cmpp_panel_mem.sv */
/*
 * Code memory array with one 8-byte write buffer per panel.
 * Assumes the sequencer pulses prog_go once per programming cycle.
 */
`timescale 1ns/1ps
module cmpp_panel_mem #(
    parameter int PANELS = 4,
    parameter int AW = 22
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Sequencer side
    cmpp_mem_if.mem mem
);
    import cmpp_pkg::*;
    localparam int DEPTH = PANELS * (2 ** PANEL_BITS);
    logic [7:0] array_q [DEPTH];
    logic [7:0] buf_q [PANELS][BUF_BYTES];
    logic [7:0] rd_q;
    logic [$clog2(PANELS > 1 ? PANELS : 2)-1:0] sel_panel;

    assign sel_panel = mem.prog_addr[PANEL_BITS +: $clog2(PANELS > 1 ? PANELS : 2)];

    // Buffer load, low byte first at even index
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int p = 0; p < PANELS; p++)
                for (int b = 0; b < BUF_BYTES; b++)
                    buf_q[p][b] <= 8'hff;
        end
        else if (mem.buf_we)
        begin
            buf_q[mem.buf_panel][{mem.buf_idx[2:1], 1'b0}] <= mem.buf_word[7:0];
            buf_q[mem.buf_panel][{mem.buf_idx[2:1], 1'b1}] <= mem.buf_word[15:8];
        end
    end

    // Programming copies buffers into the array at the same panel offset
    always_ff @(posedge clock)
    begin
        if (mem.prog_go)
        begin
            for (int p = 0; p < PANELS; p++)
                if (mem.prog_multi || p == int'(sel_panel))
                    for (int b = 0; b < BUF_BYTES; b++)
                        array_q[p * (2 ** PANEL_BITS)
                            + int'({mem.prog_addr[PANEL_BITS-1:3], 3'h0}) + b]
                            <= buf_q[p][b];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            rd_q <= 8'h00;
        else
            rd_q <= array_q[int'(mem.rd_addr) % DEPTH];
    end
    assign mem.rd_data = rd_q;
endmodule : cmpp_panel_mem

/* rtl/cmpp_programmer.sv */
/*
 * Serial programming sequencer for the code memory panels.
 * Assumes the programmer drives serial_clock and serial_data_line
 * asynchronously; bits are taken on serial clock falling edges, LSB first.
 */
// Function
// - Each panel has an 8-byte write buffer, filled fully before programming.
// - Programming copies the buffer of the panel addressed by the pointer into code memory.
// - Multi-panel mode programs all panel buffers at the same offset.
// - Writing 40h to 3C0006h in config space enables multi-panel mode.
// - Command 1101 stores two bytes low first, pointer advances by 2; 1100 stores only.
// - Command 1111 stores the last two bytes and starts programming.
// - Programming lasts while the fourth clock of the following no-op stays high.
// - Programming ends at clock fall; programmer then holds clock low for discharge.
`timescale 1ns/1ps
module cmpp_programmer #(
    parameter int PANELS = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial link
    input wire logic serial_clock,
    input wire logic serial_data_line,
    // Status
    output logic programming,
    output logic multi_panel,
    output logic [cmpp_pkg::PTR_BITS-1:0] table_pointer,
    output logic [7:0] memory_control_reg,
    // Readback of the array
    input wire logic [cmpp_pkg::PTR_BITS-1:0] read_addr,
    output logic [7:0] read_data
);
    import cmpp_pkg::*;

    if (PANELS < 1 || PANELS * (2 ** PANEL_BITS) > 2 ** PTR_BITS)
    begin : panels_range_check
        $error("cmpp_programmer: PANELS out of range");
    end

    localparam int PW = $clog2(PANELS > 1 ? PANELS : 2);

    cmpp_mem_if #(.PANELS(PANELS), .AW(PTR_BITS)) mif ();

    logic sclk_m_q, sclk_s_q, sclk_p_q, data_m_q, data_s_q;
    logic [4:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic frame_done;
    logic [FRAME_BITS-1:0] frame;
    logic sclk_fall, sclk_rise;
    cmpp_state_type state_q;
    logic [7:0] wreg_q;
    logic [PTR_BITS-1:0] ptr_q;
    logic [7:0] mc_q;
    logic [7:0] prog_ctrl_q;
    logic [3:0] cmd;
    logic [15:0] pay;
    logic is_write;

    // Two-stage synchronisers; third stage for edge detection
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclk_m_q <= 1'b0;
            sclk_s_q <= 1'b0;
            sclk_p_q <= 1'b0;
            data_m_q <= 1'b0;
            data_s_q <= 1'b0;
        end
        else
        begin
            sclk_m_q <= serial_clock;
            sclk_s_q <= sclk_m_q;
            sclk_p_q <= sclk_s_q;
            data_m_q <= serial_data_line;
            data_s_q <= data_m_q;
        end
    end
    assign sclk_fall = sclk_p_q && !sclk_s_q;
    assign sclk_rise = !sclk_p_q && sclk_s_q;

    // Frame shifter: 4-bit command then 16-bit payload, LSB first
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bit_cnt_q <= 5'h00;
            shift_q <= '0;
        end
        else if (sclk_fall)
        begin
            // The fall that ends programming is still a bit of the no-op frame
            shift_q <= {data_s_q, shift_q[FRAME_BITS-1:1]};
            if (bit_cnt_q == 5'(FRAME_BITS - 1))
                bit_cnt_q <= 5'h00;
            else
                bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end
    assign frame_done = sclk_fall && state_q != CMPP_PROGRAM
        && bit_cnt_q == 5'(FRAME_BITS - 1);
    assign frame = {data_s_q, shift_q[FRAME_BITS-1:1]};
    assign cmd = frame[CMD_BITS-1:0];
    assign pay = frame[FRAME_BITS-1:CMD_BITS];
    assign is_write = frame_done && (cmd == CMD_WRITE || cmd == CMD_WRITE_INC
        || cmd == CMD_WRITE_START);

    // Core instruction execution: working register, pointer, memory control
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wreg_q <= 8'h00;
            mc_q <= MC_RESET;
        end
        else if (frame_done && cmd == CMD_CORE)
        begin
            if (pay[15:8] == OP_MOVLW)
                wreg_q <= pay[7:0];
            else if (pay == CORE_SET_WRITE_ENABLE_BIT)
                mc_q[MC_WRITE_ENABLE_BIT_BIT] <= 1'b1;
            else if (pay[7:0] == REG_MC && pay[15:12] == OP_BSF)
                mc_q[pay[11:9]] <= 1'b1;
            else if (pay[7:0] == REG_MC && pay[15:12] == OP_BCF)
                mc_q[pay[11:9]] <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            ptr_q <= '0;
        else if (frame_done && cmd == CMD_CORE && pay[15:8] == OP_MOVWF)
        begin
            if (pay[7:0] == REG_PTR_U)
                ptr_q[PTR_BITS-1:16] <= wreg_q[PTR_BITS-17:0];
            else if (pay[7:0] == REG_PTR_H)
                ptr_q[15:8] <= wreg_q;
            else if (pay[7:0] == REG_PTR_L)
                ptr_q[7:0] <= wreg_q;
        end
        else if (frame_done && cmd == CMD_CORE && pay[15:8] == OP_CLRF)
        begin
            if (pay[7:0] == REG_PTR_U)
                ptr_q[PTR_BITS-1:16] <= '0;
            else if (pay[7:0] == REG_PTR_H)
                ptr_q[15:8] <= 8'h00;
            else if (pay[7:0] == REG_PTR_L)
                ptr_q[7:0] <= 8'h00;
        end
        else if (frame_done && cmd == CMD_WRITE_INC)
            ptr_q <= ptr_q + PTR_STEP;
    end

    // Programming control register in configuration space
    always_ff @(posedge clock)
    begin
        if (rst)
            prog_ctrl_q <= PROG_CTRL_RESET;
        else if (is_write && mc_q[MC_CFG_BIT] && mc_q[MC_WRITE_ENABLE_BIT_BIT]
            && ptr_q == PROG_CTRL_ADDR)
            prog_ctrl_q <= pay[7:0];
    end

    // Start, no-op hold, end on clock fall
    always_ff @(posedge clock)
    begin
        if (rst)
            state_q <= CMPP_IDLE;
        else
        begin
            case (state_q)
                CMPP_IDLE:
                    if (frame_done && cmd == CMD_WRITE_START && !mc_q[MC_CFG_BIT]
                        && mc_q[MC_WRITE_ENABLE_BIT_BIT])
                        state_q <= CMPP_WAIT_NOP;
                CMPP_WAIT_NOP:
                    if (sclk_rise && bit_cnt_q == (NOP_HOLD_EDGE - 5'h01))
                        state_q <= CMPP_PROGRAM;
                CMPP_PROGRAM:
                    if (sclk_fall)
                        state_q <= CMPP_WAIT_NOP;
                default:
                    state_q <= CMPP_IDLE;
            endcase
            if (state_q == CMPP_WAIT_NOP && frame_done)
                state_q <= CMPP_IDLE;
        end
    end

    // Buffer loads into the panel addressed by the pointer
    assign mif.buf_we = is_write && !mc_q[MC_CFG_BIT] && mc_q[MC_WRITE_ENABLE_BIT_BIT];
    assign mif.buf_panel = PW'(ptr_q[PANEL_BITS +: PW]);
    assign mif.buf_idx = ptr_q[2:0];
    assign mif.buf_word = pay;
    assign mif.prog_go = state_q == CMPP_WAIT_NOP && sclk_rise
        && bit_cnt_q == (NOP_HOLD_EDGE - 5'h01);
    assign mif.prog_multi = prog_ctrl_q[PROG_CTRL_MULTI_BIT];
    assign mif.prog_addr = ptr_q;
    assign mif.rd_addr = read_addr;

    cmpp_panel_mem #(.PANELS(PANELS), .AW(PTR_BITS)) u_mem (
        .clock(clock),
        .rst(rst),
        .mem(mif)
    );

    assign programming = state_q == CMPP_PROGRAM;
    assign multi_panel = prog_ctrl_q[PROG_CTRL_MULTI_BIT];
    assign table_pointer = ptr_q;
    assign memory_control_reg = mc_q;
    assign read_data = mif.rd_data;
endmodule : cmpp_programmer

/* test/cmpp_programmer_properties.sv */
/*
 * Port checker for the code memory panel programmer.
 * Assumes it is bound to cmpp_programmer and sees only its ports.
 */
`timescale 1ns/1ps
module cmpp_programmer_properties #(
    parameter int PANELS = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial link
    input wire logic serial_clock,
    input wire logic serial_data_line,
    // Status and readback
    input wire logic programming,
    input wire logic multi_panel,
    input wire logic [cmpp_pkg::PTR_BITS-1:0] table_pointer,
    input wire logic [7:0] memory_control_reg,
    input wire logic [cmpp_pkg::PTR_BITS-1:0] read_addr,
    input wire logic [7:0] read_data
);
    import cmpp_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_reset_clears: assert property (disable iff (1'b0)
        rst |=> !programming && !multi_panel && table_pointer == '0 && memory_control_reg == '0)
        else $error("state not cleared by reset");
    chk_prog_ends: assert property (
        $fell(serial_clock) |-> ##[1:5] !programming)
        else $error("programming outlived the serial clock");
    chk_prog_starts: assert property (
        $rose(programming) |-> serial_clock)
        else $error("programming began with serial clock low");
    chk_mode_steady: assert property (
        programming |=> $stable(multi_panel))
        else $error("mode changed while programming");
    chk_ptr_quiet: assert property (
        $changed(table_pointer) && !$past(rst) |-> !serial_clock)
        else $error("pointer moved mid frame");
    chk_mc_quiet: assert property (
        $changed(memory_control_reg) && !$past(rst) |-> !serial_clock)
        else $error("control bits moved mid frame");
    chk_multi_enable: assert property (
        $rose(multi_panel) |-> memory_control_reg[MC_CFG_BIT]
            && memory_control_reg[MC_WRITE_ENABLE_BIT_BIT] && table_pointer == PROG_CTRL_ADDR)
        else $error("multi panel set without a legal write");
    chk_prog_enabled: assert property (
        $rose(programming) |-> !memory_control_reg[MC_CFG_BIT] && memory_control_reg[MC_WRITE_ENABLE_BIT_BIT])
        else $error("programming began with writes disabled");
endmodule : cmpp_programmer_properties

bind cmpp_programmer cmpp_programmer_properties #(.PANELS(PANELS)) chk_i (.clock(clock),
    .rst(rst), .serial_clock(serial_clock), .serial_data_line(serial_data_line),
    .programming(programming), .multi_panel(multi_panel), .table_pointer(table_pointer),
    .memory_control_reg(memory_control_reg), .read_addr(read_addr), .read_data(read_data));

/* test/cmpp_serial_host.sv */
/*
 * Behavioural external programmer: sends one 20-bit frame per request.
 * Assumes go is raised at a clock edge and held until busy is seen.
 */
`timescale 1ns/1ps
module cmpp_serial_host (
    // Bench side
    input wire logic clock,
    input wire logic go,
    input wire logic [19:0] frame,
    input wire logic [15:0] hold,
    output logic busy,
    // Serial link
    output logic serial_clock,
    output logic serial_data_line
);
    initial
    begin
        busy = 1'b0;
        serial_clock = 1'b0;
        serial_data_line = 1'b1;
        forever
        begin
            @(posedge clock);
            if (go === 1'b1)
            begin
                #1 busy = 1'b1;
                #12;
                for (int i = 0; i < 20; i++)
                begin
                    serial_clock = 1'b1;
                    serial_data_line = frame[i];
                    #160;
                    if (i == 3)
                        #(hold * 40);
                    serial_clock = 1'b0;
                    #160;
                end
                // Released line shows the inverse, clock rests low for discharge
                serial_data_line = ~serial_data_line;
                #200 busy = 1'b0;
            end
        end
    end
endmodule : cmpp_serial_host

/* test/cmpp_programmer_bench.sv */
/*
 * Self-checking bench: drives frames through the host model, checks ports.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module cmpp_programmer_bench;
    import cmpp_pkg::*;
    localparam int PN = 4;
    logic clock, rst, go, busy, serial_clock, serial_data_line, programming, multi_panel;
    logic [19:0] frame;
    logic [15:0] hold;
    logic [21:0] table_pointer, read_addr;
    logic [7:0] memory_control_reg, read_data;
    int err_count, compares, hi_count, n0, d;

    cmpp_programmer #(.PANELS(PN)) cmpp_programmer_i (.clock, .rst, .serial_clock,
        .serial_data_line, .programming, .multi_panel, .table_pointer, .memory_control_reg,
        .read_addr, .read_data);
    cmpp_serial_host cmpp_serial_host_i (.clock, .go, .frame, .hold, .busy, .serial_clock,
        .serial_data_line);

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
        if (programming === 1'b1)
            hi_count <= hi_count + 1;

    task check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task give_verdict;
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task send(logic [3:0] c, logic [15:0] p, logic [15:0] h = 16'h0000);
        int n;
        n = 0;
        frame <= {p, c};
        hold <= h;
        go <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (busy !== 1'b1 && n < 3000);
        go <= 1'b0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= 3000)
        begin
            err_count++;
            give_verdict();
        end
    endtask : send

    task set_ptr(logic [21:0] a);
        send(CMD_CORE, {OP_MOVLW, 2'b00, a[21:16]});
        send(CMD_CORE, {OP_MOVWF, REG_PTR_U});
        send(CMD_CORE, {OP_MOVLW, a[15:8]});
        send(CMD_CORE, {OP_MOVWF, REG_PTR_H});
        send(CMD_CORE, {OP_MOVLW, a[7:0]});
        send(CMD_CORE, {OP_MOVWF, REG_PTR_L});
        check("table_pointer", a, table_pointer);
    endtask : set_ptr

    initial
    begin
        rst = 1'b1;
        go = 1'b0;
        frame = '0;
        hold = '0;
        read_addr = '0;
        hi_count = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check("programming", 0, programming);
        check("multi_panel", 0, multi_panel);
        check("memory_control_reg", MC_RESET, memory_control_reg);
        $display("reset test done");
        send(CMD_CORE, 16'h8ea6);
        send(CMD_CORE, 16'h8ca6);
        set_ptr(PROG_CTRL_ADDR);
        send(CMD_WRITE, {8'h00, PROG_CTRL_MULTI_VAL});
        check("multi_panel", 0, multi_panel);
        send(CMD_CORE, 16'h86a6);
        check("memory_control_reg", 8'hc4, memory_control_reg);
        send(CMD_WRITE, {8'h00, PROG_CTRL_MULTI_VAL});
        check("multi_panel", 1, multi_panel);
        send(CMD_CORE, 16'h9ca6);
        check("memory_control_reg", 8'h84, memory_control_reg);
        $display("control test done");
        send(CMD_CORE, {OP_CLRF, REG_PTR_U});
        send(CMD_CORE, {OP_CLRF, REG_PTR_H});
        send(CMD_CORE, {OP_CLRF, REG_PTR_L});
        check("table_pointer", 0, table_pointer);
        for (int r = 1; r <= 2; r++)
        begin
            for (int p = 0; p < PN; p++)
            begin
                set_ptr(22'(p * 32'h2000 + 8 * r));
                for (int w = 0; w < 4; w++)
                begin
                    d = r * 64 + p * 16 + w * 2;
                    send(w < 3 ? CMD_WRITE_INC : (p == PN - 1 ? CMD_WRITE_START : CMD_WRITE),
                        {8'(d + 1), 8'(d)});
                    check("table_pointer", p * 32'h2000 + 8 * r + 2 * (w < 3 ? w + 1 : 3),
                        table_pointer);
                end
            end
            check("table_pointer", (PN - 1) * 32'h2000 + 8 * r + 6, table_pointer);
            check("programming", 0, programming);
            n0 = hi_count;
            send(CMD_CORE, 16'h0000, 16'd50);
            check("programming width", 1, (hi_count - n0) inside {[52:57]});
            check("programming", 0, programming);
        end
        $display("programming test done");
        for (int a = 0; a < PN * 16; a++)
        begin
            read_addr <= 22'((a / 16) * 32'h2000 + 8 + a % 16);
            repeat (2) @(posedge clock);
            check("read_data", 64 * (1 + (a % 16) / 8) + (a / 16) * 16 + a % 8,
                read_data);
        end
        $display("readback test done");
        give_verdict();
    end
endmodule : cmpp_programmer_bench
